// file: pkg/mac_rx_defines.svh
// constants of the receive control and status block
`ifndef MAC_RX_DEFINES_SVH
`define MAC_RX_DEFINES_SVH

// ----------------------------------------------------------------------
// register byte addresses and reset values
// ----------------------------------------------------------------------
`define ADDR_RX_CONTROL     16'hA010
`define ADDR_RX_STATUS      16'hA014
`define ADDR_MGMT_DATA      16'hA018
`define RST_RX_CONTROL      32'h00000000
`define RST_RX_STATUS       32'h00000000
`define RST_MGMT_DATA       16'h0000

// ----------------------------------------------------------------------
// rx_control bit positions
// ----------------------------------------------------------------------
`define CTL_RX_ENABLE       0
`define CTL_HALT_REQUEST    1
`define CTL_LONG_ENABLE     2
`define CTL_SHORT_ENABLE    3
`define CTL_CRC_STRIP       4
`define CTL_CONTROL_PASS    5
`define CTL_CRC_IGNORE      6
`define CTL_PARITY_IRQ_EN   13
`define CTL_WRITE_MASK      32'h00006F7F

// ----------------------------------------------------------------------
// rx_status bit positions
// ----------------------------------------------------------------------
`define ST_CONTROL_FRAME    5
`define ST_RX_INTERRUPT     6
`define ST_TEN_MEG          7
`define ST_ALIGN_ERROR      8
`define ST_CRC_ERROR        9
`define ST_OVERFLOW         10
`define ST_LONG_ERROR       11
`define ST_RX_PARITY        13
`define ST_GOOD_FRAME       14
`define ST_RX_HALTED        15
`define ST_FRAME_MASK       32'h00004FE0
`define IRQ_MASK            32'h00006F00

// ----------------------------------------------------------------------
// frame constants
// ----------------------------------------------------------------------
`define MAX_FRAME_LEN       12'd1518
`define MIN_FRAME_LEN       12'd64
`define LEN_SATURATE        12'hFFF
`define TYPE_HI_INDEX       12'd12
`define TYPE_LO_INDEX       12'd13
`define CONTROL_TYPE        16'h8808
`define SFD_NIBBLE          4'hD
`define CRC_INIT            32'hFFFFFFFF
`define CRC_POLY            32'hEDB88320
`define CRC_RESIDUE         32'hDEBB20E3
`define FCS_BYTES           3'd4
`define STEP_MII            4'd4
`define STEP_SERIAL         4'd1

`endif

// file: pkg/mac_rx_pkg.sv
// types of the receive control and status block
package mac_rx_pkg;

    // ------------------------------------------------------------------
    // receive sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_OFF   = 6'b000001,
        ST_IDLE  = 6'b000010,
        ST_PRE   = 6'b000100,
        ST_DATA  = 6'b001000,
        ST_FLUSH = 6'b010000,
        ST_SKIP  = 6'b100000
    } rx_state_t;

endpackage

// file: design/mac_receive_control_status.sv
// receive control, frame classification and status flags of an ethernet mac
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
//
// The APB slave port was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "mac_rx_defines.svh"

module mac_receive_control_status
    import mac_rx_pkg::*;
(
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_nrst,
    // apb slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [15:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // phy receive pins
    input  wire logic        i_rx_clk,
    input  wire logic        i_rx_dv,
    input  wire logic        i_rx_er,
    input  wire logic [3:0]  i_rxd,
    // mac context
    input  wire logic        i_seven_wire,
    input  wire logic        i_halt_immediate,
    input  wire logic        i_addr_match,
    // receive fifo side
    input  wire logic        i_fifo_full,
    input  wire logic        i_fifo_parity_err,
    output logic      [7:0]  o_rx_byte,
    output logic             o_rx_byte_valid,
    output logic             o_frame_done,
    output logic             o_frame_accept,
    // station management
    input  wire logic        i_mgmt_load,
    input  wire logic [15:0] i_mgmt_rdata,
    output logic      [15:0] o_mgmt_data,
    // interrupt
    output logic             o_rx_irq
);

    // ------------------------------------------------------------------
    // crc step over one to four bits, lsb first
    // ------------------------------------------------------------------
    function automatic logic [31:0] crc_step(input logic [31:0] crc,
                                             input logic [3:0]  bits,
                                             input logic [3:0]  n);
        logic [31:0] c;
        c = crc;
        for (int i = 0; i < 4; i++) begin
            if (4'(i) < n) begin
                c = (c[0] ^ bits[i]) ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
            end
        end
        return c;
    endfunction

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [31:0] rx_control;
    logic [31:0] rx_status;
    logic [15:0] mgmt_data;
    rx_state_t   state;
    rx_state_t   next_state;
    logic [6:0]  sync1;
    logic [6:0]  sync2;
    logic        clk_d;
    logic        en_d;
    logic        himm_d;
    logic        prev_bit;
    logic [7:0]  shifter;
    logic [2:0]  bit_cnt;
    logic [11:0] byte_cnt;
    logic [31:0] crc;
    logic [15:0] frame_type;
    logic        er_seen;
    logic        ovf_seen;
    logic        par_seen;
    logic [7:0]  dline [4];
    logic [2:0]  dl_cnt;

    // ------------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            sync1 <= 7'h00;
            sync2 <= 7'h00;
            clk_d <= 1'b0;
        end else begin
            sync1 <= {i_rx_clk, i_rx_dv, i_rx_er, i_rxd};
            sync2 <= sync1;
            clk_d <= sync2[6];
        end
    end

    wire        s_dv   = sync2[5];
    wire        s_er   = sync2[4];
    wire [3:0]  s_rxd  = sync2[3:0];
    wire        step   = sync2[6] & ~clk_d;
    wire [3:0]  n_bits = i_seven_wire ? `STEP_SERIAL : `STEP_MII;
    wire [3:0]  bit_sum = {1'b0, bit_cnt} + n_bits;
    wire        byte_done = (state == ST_DATA) && step && bit_sum[3];
    wire [7:0]  new_byte = i_seven_wire ? {s_rxd[0], shifter[7:1]}
                                        : {s_rxd, shifter[7:4]};

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    wire        sel_ctl  = (i_paddr == `ADDR_RX_CONTROL);
    wire        sel_st   = (i_paddr == `ADDR_RX_STATUS);
    wire        sel_md   = (i_paddr == `ADDR_MGMT_DATA);
    wire        mapped   = sel_ctl | sel_st | sel_md;
    wire        setup    = i_psel & ~i_penable;
    wire        wr_acc   = i_psel & i_penable & i_pwrite & mapped;
    wire [31:0] st_clear = (wr_acc && sel_st) ? (i_pwdata & `ST_FRAME_MASK)
                           | (i_pwdata & (32'h1 << `ST_RX_PARITY))
                           | (i_pwdata & (32'h1 << `ST_RX_HALTED)) : 32'h0;
    // reserved bits are masked on write, so they read back as zero
    wire [31:0] rd_mux   = sel_ctl ? rx_control :
                           sel_st  ? rx_status  :
                           sel_md  ? {16'h0000, mgmt_data} : 32'h0;

    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel & i_penable & ~mapped;

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_prdata <= 32'h0;
        end else if (setup && !i_pwrite) begin
            o_prdata <= rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------
    wire par_event = i_fifo_parity_err;
    wire par_stop  = par_event & rx_control[`CTL_PARITY_IRQ_EN];

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            rx_control <= `RST_RX_CONTROL;
        end else begin
            if (wr_acc && sel_ctl) begin
                rx_control <= i_pwdata & `CTL_WRITE_MASK;
            end
            if (par_stop) begin
                rx_control[`CTL_RX_ENABLE] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // management data register
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            mgmt_data <= `RST_MGMT_DATA;
        end else if (i_mgmt_load) begin
            mgmt_data <= i_mgmt_rdata;
        end else if (wr_acc && sel_md) begin
            mgmt_data <= i_pwdata[15:0];
        end
    end

    assign o_mgmt_data = mgmt_data;

    // ------------------------------------------------------------------
    // receive sequencer
    // ------------------------------------------------------------------
    wire active   = rx_control[`CTL_RX_ENABLE] & ~i_halt_immediate;
    wire halt_req = rx_control[`CTL_HALT_REQUEST];
    wire sfd_hit  = step && (i_seven_wire ? (prev_bit & s_rxd[0])
                                          : (s_rxd == `SFD_NIBBLE));
    wire finalize = active && (state == ST_FLUSH) &&
                    (rx_control[`CTL_CRC_STRIP] || dl_cnt == 3'd0);

    always_comb begin
        next_state = state;
        case (state)
            ST_OFF: begin
                if (active && !halt_req) begin
                    next_state = s_dv ? ST_SKIP : ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (halt_req) begin
                    next_state = ST_OFF;
                end else if (s_dv) begin
                    next_state = ST_PRE;
                end
            end
            ST_PRE: begin
                if (!s_dv) begin
                    next_state = ST_IDLE;
                end else if (sfd_hit) begin
                    next_state = ST_DATA;
                end
            end
            ST_DATA: begin
                if (!s_dv) begin
                    next_state = ST_FLUSH;
                end
            end
            ST_FLUSH: begin
                if (finalize) begin
                    next_state = ST_IDLE;
                end
            end
            ST_SKIP: begin
                if (!s_dv) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_OFF;
        endcase
        if (!active) begin
            next_state = ST_OFF;
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // bit and byte assembly, crc, type capture
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            prev_bit   <= 1'b0;
            shifter    <= 8'h00;
            bit_cnt    <= 3'd0;
            byte_cnt   <= 12'd0;
            crc        <= `CRC_INIT;
            frame_type <= 16'h0000;
            er_seen    <= 1'b0;
        end else if (state == ST_PRE) begin
            // counters restart so the preamble and delimiter never count
            if (step) begin
                prev_bit <= s_rxd[0];
            end
            shifter  <= 8'h00;
            bit_cnt  <= 3'd0;
            byte_cnt <= 12'd0;
            crc      <= `CRC_INIT;
            er_seen  <= 1'b0;
        end else if (state == ST_DATA && step) begin
            shifter <= new_byte;
            prev_bit <= 1'b0;
            bit_cnt <= bit_sum[2:0];
            crc     <= crc_step(crc, s_rxd, n_bits);
            if (s_er) begin
                er_seen <= 1'b1;
            end
            if (bit_sum[3] && byte_cnt != `LEN_SATURATE) begin
                byte_cnt <= byte_cnt + 12'd1;
            end
            if (bit_sum[3] && byte_cnt == `TYPE_HI_INDEX) begin
                frame_type[15:8] <= new_byte;
            end
            if (bit_sum[3] && byte_cnt == `TYPE_LO_INDEX) begin
                frame_type[7:0] <= new_byte;
            end
        end
    end

    // ------------------------------------------------------------------
    // four byte delay line holds back the fcs for stripping
    // ------------------------------------------------------------------
    wire emit_run   = byte_done && dl_cnt == `FCS_BYTES;
    wire emit_flush = (state == ST_FLUSH) && !rx_control[`CTL_CRC_STRIP]
                      && dl_cnt != 3'd0;
    wire emit       = emit_run | emit_flush;

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            dl_cnt <= 3'd0;
            for (int i = 0; i < 4; i++) begin
                dline[i] <= 8'h00;
            end
        end else if (state == ST_PRE || state == ST_OFF) begin
            dl_cnt <= 3'd0;
        end else if (emit_run) begin
            dline[0] <= dline[1];
            dline[1] <= dline[2];
            dline[2] <= dline[3];
            dline[3] <= new_byte;
        end else if (byte_done) begin
            dline[dl_cnt[1:0]] <= new_byte;
            dl_cnt             <= dl_cnt + 3'd1;
        end else if (emit_flush) begin
            dline[0] <= dline[1];
            dline[1] <= dline[2];
            dline[2] <= dline[3];
            dl_cnt   <= dl_cnt - 3'd1;
        end else if (finalize) begin
            dl_cnt <= 3'd0;
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rx_byte       <= 8'h00;
            o_rx_byte_valid <= 1'b0;
            ovf_seen        <= 1'b0;
        end else begin
            o_rx_byte_valid <= emit & ~i_fifo_full;
            if (emit) begin
                o_rx_byte <= dline[0];
            end
            if (state == ST_PRE) begin
                ovf_seen <= 1'b0;
            end else if (emit && i_fifo_full) begin
                ovf_seen <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // frame classification
    // ------------------------------------------------------------------
    wire crc_bad   = !rx_control[`CTL_CRC_IGNORE] && crc != `CRC_RESIDUE;
    wire align_err = (bit_cnt != 3'd0) && crc_bad;
    wire crc_err   = crc_bad | er_seen;
    wire too_long  = byte_cnt > `MAX_FRAME_LEN;
    wire long_err  = too_long && !rx_control[`CTL_LONG_ENABLE];
    wire short_rej = byte_cnt < `MIN_FRAME_LEN
                     && !rx_control[`CTL_SHORT_ENABLE];
    wire is_ctl    = frame_type == `CONTROL_TYPE && i_addr_match
                     && byte_cnt == `MIN_FRAME_LEN;
    wire good      = !(align_err | crc_err | ovf_seen | long_err | par_seen
                       | short_rej);
    wire accept    = good && (!is_ctl || rx_control[`CTL_CONTROL_PASS]);

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            par_seen <= 1'b0;
        end else if (state == ST_PRE) begin
            par_seen <= 1'b0;
        end else if (par_event) begin
            par_seen <= 1'b1;
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_frame_done   <= 1'b0;
            o_frame_accept <= 1'b0;
        end else begin
            o_frame_done   <= finalize;
            o_frame_accept <= finalize & accept;
        end
    end

    // ------------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------------
    logic [31:0] frame_ev;
    logic [31:0] ev;

    always_comb begin
        frame_ev = 32'h0;
        frame_ev[`ST_CONTROL_FRAME] = is_ctl;
        frame_ev[`ST_TEN_MEG]       = i_seven_wire;
        frame_ev[`ST_ALIGN_ERROR]   = align_err;
        frame_ev[`ST_CRC_ERROR]     = crc_err;
        frame_ev[`ST_OVERFLOW]      = ovf_seen;
        frame_ev[`ST_LONG_ERROR]    = long_err;
        frame_ev[`ST_GOOD_FRAME]    = good;
        frame_ev[`ST_RX_INTERRUPT]  = |(frame_ev & rx_control & `IRQ_MASK);
        if (!finalize) begin
            frame_ev = 32'h0;
        end
        ev = frame_ev;
        ev[`ST_RX_PARITY] = par_event;
        ev[`ST_RX_HALTED] = (en_d & ~rx_control[`CTL_RX_ENABLE])
                            | (i_halt_immediate & ~himm_d);
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            rx_status <= `RST_RX_STATUS;
            en_d      <= 1'b0;
            himm_d    <= 1'b0;
        end else begin
            en_d   <= rx_control[`CTL_RX_ENABLE];
            himm_d <= i_halt_immediate;
            // a new frame replaces the frame flags; a set beats a clear
            rx_status <= (rx_status & ~st_clear
                          & ~(finalize ? `ST_FRAME_MASK : 32'h0)) | ev;
        end
    end

    assign o_rx_irq = |(rx_status & rx_control & `IRQ_MASK);

endmodule // mac_receive_control_status
`default_nettype wire

// file: verif/mac_rx_asserts.sv
// concurrent checks on the register and frame end side of the receive control and status block
`timescale 1ns/1ns
`default_nettype none
module mac_rx_checker (
    // clock, reset and apb
    input wire logic        i_clock,
    input wire logic        i_nrst,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [15:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pslverr,
    // frame end and management
    input wire logic        o_frame_done,
    input wire logic        o_frame_accept,
    input wire logic        i_mgmt_load,
    input wire logic [15:0] i_mgmt_rdata,
    input wire logic [15:0] o_mgmt_data
);
    // --------
    // access decode
    // --------
    wire logic acc = i_psel && i_penable;
    wire logic rd  = acc && !i_pwrite;
    wire logic wr  = acc && i_pwrite;
    wire logic hit = i_paddr inside {16'hA010, 16'hA014, 16'hA018};
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    unmapped_err_a: assert property (acc && !hit |-> o_pslverr)
        else $error("no slave error on unmapped access");
    mapped_ok_a: assert property (acc && hit |-> !o_pslverr)
        else $error("slave error on mapped access");
    ctl_reserved_a: assert property (rd && i_paddr == 16'hA010 |->
        (o_prdata & 32'hFFFF9080) == 32'h0) else $error("control reserved bits set");
    stat_reserved_a: assert property (rd && i_paddr == 16'hA014 |->
        (o_prdata & 32'hFFFF101F) == 32'h0) else $error("status reserved bits set");
    unmapped_zero_a: assert property (rd && !hit |-> o_prdata == 32'h0)
        else $error("unmapped read not zero");
    mgmt_load_a: assert property (i_mgmt_load |=> o_mgmt_data == $past(i_mgmt_rdata))
        else $error("management load lost");
    mgmt_write_a: assert property (wr && i_paddr == 16'hA018 && !i_mgmt_load
        |=> o_mgmt_data == $past(i_pwdata[15:0])) else $error("management write lost");
    stop_now_a: assert property (wr && i_paddr == 16'hA010 && !i_pwdata[0]
        |=> ##1 !o_frame_done [*8]) else $error("frame ended after receive off");
    accept_done_a: assert property (o_frame_accept |-> o_frame_done)
        else $error("accept without frame end");
    cover property (o_frame_accept);
    cover property (wr && i_paddr == 16'hA014);
    cover property (acc && !hit);
endmodule // mac_rx_checker

bind mac_receive_control_status mac_rx_checker i_mac_rx_checker (
    .i_clock, .i_nrst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
    .o_pslverr, .o_frame_done, .o_frame_accept, .i_mgmt_load, .i_mgmt_rdata, .o_mgmt_data
);
`default_nettype wire

// file: verif/phy_model.sv
// receive side of a phy: mii nibbles or seven wire serial bits
`timescale 1ns/1ns
`default_nettype none
module phy_model #(parameter int HALF = 40) (
    // phy receive pins
    output logic       o_rx_clk,
    output logic       o_rx_dv,
    output logic       o_rx_er,
    output logic [3:0] o_rxd
);
    logic [7:0] fr [0:1599];
    initial begin
        {o_rx_clk, o_rx_dv, o_rx_er, o_rxd} = 7'h00;
    end
    // --------
    // one frame: preamble, delimiter, n bytes, fcs
    // --------
    task automatic tick;
        #HALF o_rx_clk = 1'b1;
        #HALF o_rx_clk = 1'b0;
    endtask
    task automatic send(input int n, input logic [15:0] typ, input logic bad,
                        input logic er, input logic ser);
        logic [31:0] c;
        c = 32'hFFFFFFFF;
        for (int i = 0; i < n; i++) begin
            fr[i+8] = (i == 12) ? typ[15:8] : (i == 13) ? typ[7:0] : i[7:0];
            for (int k = 0; k < 8; k++)
                c = (c[0] ^ fr[i+8][k]) ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
        end
        c = ~c ^ {31'h0, bad};
        for (int k = 0; k < 4; k++)
            fr[n+8+k] = c[8*k+:8];
        for (int k = 0; k < 7; k++)
            fr[k] = 8'h55;
        fr[7] = 8'hD5;
        o_rx_dv = 1'b1;
        for (int k = 0; k < n + 12; k++)
            for (int b = 0; b < 8; b += ser ? 1 : 4) begin
                o_rxd = ser ? {3'b000, fr[k][b]} : fr[k][b+:4];
                o_rx_er = er && k == 20;
                tick();
            end
        o_rx_dv = 1'b0;
        o_rx_er = 1'b0;
        repeat (2) begin
            o_rxd = ~o_rxd;
            tick();
        end
    endtask
endmodule // phy_model
`default_nettype wire

// file: verif/testbench.sv
// self-checking bench of the receive control and status block
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        i_clock, i_nrst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
    logic [15:0] i_paddr, i_mgmt_rdata, o_mgmt_data;
    logic [31:0] i_pwdata, o_prdata, q;
    logic        i_rx_clk, i_rx_dv, i_rx_er, i_seven_wire, i_halt_immediate, i_addr_match;
    logic        i_fifo_full, i_fifo_parity_err, o_rx_byte_valid, o_frame_done;
    logic        o_frame_accept, i_mgmt_load, o_rx_irq, err, acc;
    logic [3:0]  i_rxd;
    logic [7:0]  o_rx_byte;
    int          bad_count, checked, cycles, nbytes, dones, d0;
    mac_receive_control_status i_mac_receive_control_status (.i_clock, .i_nrst, .i_psel,
        .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
        .i_rx_clk, .i_rx_dv, .i_rx_er, .i_rxd, .i_seven_wire, .i_halt_immediate,
        .i_addr_match, .i_fifo_full, .i_fifo_parity_err, .o_rx_byte, .o_rx_byte_valid,
        .o_frame_done, .o_frame_accept, .i_mgmt_load, .i_mgmt_rdata, .o_mgmt_data, .o_rx_irq);
    phy_model i_phy_model (.o_rx_clk(i_rx_clk), .o_rx_dv(i_rx_dv), .o_rx_er(i_rx_er),
        .o_rxd(i_rxd));
    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        nbytes <= nbytes + o_rx_byte_valid;
        if (o_frame_done === 1'b1) begin
            dones <= dones + 1;
            acc <= o_frame_accept;
        end
        if (cycles == 80000) begin
            bad_count++;
            results();
        end
    end
    // --------
    // bus, compare and frame tasks
    // --------
    task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clock);
        i_penable <= 1'b1;
        @(posedge i_clock);
        while (o_pready !== 1'b1) @(posedge i_clock);
        {q, err} = {o_prdata, o_pslverr};
        {i_psel, i_penable} <= 2'b00;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic run(input logic [31:0] ctl, input int n, input logic [15:0] typ,
        input logic bad, er, ser, full, input logic [31:0] st, input int ac);
        xfer(1'b1, 16'hA014, 32'hFFFFFFFF);
        xfer(1'b1, 16'hA010, ctl);
        {i_seven_wire, i_fifo_full} <= {ser, full};
        nbytes = 0;
        d0 = dones;
        i_phy_model.send(n, typ, bad, er, ser);
        for (int i = 0; i < 200 && dones == d0; i++) @(posedge i_clock);
        xfer(1'b0, 16'hA014, 32'h0);
        chk(q, st);
        chk(o_rx_irq, |(st & ctl & 32'h6F00));
        if (ac < 2) chk(acc, ac);
        if (ac == 1) chk(nbytes, n + (ctl[4] ? 0 : 4));
        {i_fifo_full, i_seven_wire} <= 2'b00;
    endtask
    // --------
    // main sequence
    // --------
    initial begin
        {i_nrst, i_psel, i_penable, i_pwrite, i_seven_wire, i_halt_immediate} = 6'h0;
        {i_fifo_full, i_fifo_parity_err, i_mgmt_load} = 3'h0;
        i_addr_match = 1'b1;
        {i_paddr, i_pwdata, i_mgmt_rdata} = 64'h0;
        repeat (3) @(posedge i_clock);
        i_nrst <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            xfer(1'b0, 16'hA010 + 16'(4 * i), 32'h0);
            chk(q, 32'h0);
        end
        xfer(1'b1, 16'hA010, 32'hFFFFFFFF);
        xfer(1'b0, 16'hA010, 32'h0);
        chk(q, 32'h6F7F);
        xfer(1'b1, 16'hA018, 32'hFFFFFFFF);
        xfer(1'b0, 16'hA018, 32'h0);
        chk(q, 32'hFFFF);
        xfer(1'b0, 16'hA020, 32'h0);
        chk(q, 32'h0);
        chk(err, 32'h1);
        i_mgmt_rdata <= 16'h1234;
        i_mgmt_load <= 1'b1;
        @(posedge i_clock);
        i_mgmt_load <= 1'b0;
        xfer(1'b0, 16'hA018, 32'h0);
        chk(q, 32'h1234);
        run(32'h4001, 60, 16'h0, 0, 0, 0, 0, 32'h4040, 1);
        run(32'h0001, 60, 16'h0, 0, 0, 0, 0, 32'h4000, 1);
        run(32'h4011, 60, 16'h0, 0, 0, 0, 0, 32'h4040, 1);
        run(32'h0201, 60, 16'h0, 1, 0, 0, 0, 32'h0240, 2);
        run(32'h4041, 60, 16'h0, 1, 0, 0, 0, 32'h4040, 1);
        run(32'h0201, 60, 16'h0, 0, 1, 0, 0, 32'h0240, 2);
        run(32'h4001, 59, 16'h0, 0, 0, 0, 0, 32'h0000, 0);
        run(32'h4009, 59, 16'h0, 0, 0, 0, 0, 32'h4040, 1);
        run(32'h0801, 1515, 16'h0, 0, 0, 0, 0, 32'h0840, 0);
        run(32'h4005, 1515, 16'h0, 0, 0, 0, 0, 32'h4040, 1);
        run(32'h4001, 60, 16'h8808, 0, 0, 0, 0, 32'h4060, 0);
        run(32'h4021, 60, 16'h8808, 0, 0, 0, 0, 32'h4060, 1);
        run(32'h4001, 60, 16'h0, 0, 0, 1, 0, 32'h40C0, 1);
        run(32'h0401, 60, 16'h0, 0, 0, 0, 1, 32'h0440, 2);
        xfer(1'b1, 16'hA014, 32'h40);
        xfer(1'b0, 16'hA014, 32'h0);
        chk(q, 32'h0400);
        for (int k = 0; k < 3; k++) begin
            xfer(1'b1, 16'hA010, 32'h1);
            xfer(1'b1, 16'hA014, 32'hFFFFFFFF);
            d0 = dones;
            fork
                i_phy_model.send(200, 16'h0, 0, 0, 0);
                begin
                    repeat (300) @(posedge i_clock);
                    if (k == 1) i_halt_immediate <= 1'b1;
                    else xfer(1'b1, 16'hA010, k == 2 ? 32'h3 : 32'h0);
                end
            join
            if (k == 2) i_phy_model.send(60, 16'h0, 0, 0, 0);
            repeat (50) @(posedge i_clock);
            chk(dones - d0, k / 2);
            xfer(1'b0, 16'hA014, 32'h0);
            chk(q, k == 2 ? 32'h4000 : 32'h8000);
            i_halt_immediate <= 1'b0;
        end
        xfer(1'b1, 16'hA010, 32'h2001);
        xfer(1'b1, 16'hA014, 32'hFFFFFFFF);
        i_fifo_parity_err <= 1'b1;
        @(posedge i_clock);
        i_fifo_parity_err <= 1'b0;
        xfer(1'b0, 16'hA014, 32'h0);
        chk(q, 32'hA000);
        chk(o_rx_irq, 32'h1);
        xfer(1'b0, 16'hA010, 32'h0);
        chk(q, 32'h2000);
        results();
    end
endmodule // testbench
`default_nettype wire
